// ---- rtl/mil_pkg.sv ----
// mil_pkg: constants and carrier types for the maskable interrupt logic
// assumes one 10 MHz core clock and an axi4-lite register bus with 32-bit data
package mil_pkg;

  localparam int          NUM_MASKABLE = 13;
  localparam int          NUM_VECTORS  = 14;

  // register byte addresses
  localparam logic [7:0]  ADDR_PENDING  = 8'h00;
  localparam logic [7:0]  ADDR_ENABLE   = 8'h04;
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;
  localparam logic [7:0]  ADDR_VECTOR   = 8'h0c;
  localparam logic [7:0]  ADDR_RET_ADDR = 8'h10;

  // status register fields
  localparam int          STAT_GIE_BIT    = 0;
  localparam int          STAT_NMI_BIT    = 1;
  localparam int          STAT_BOOT_BIT   = 2;
  localparam int          STAT_ACK_BIT    = 3;

  // reset values
  localparam logic [12:0] PENDING_RESET = 13'h0000;
  localparam logic [12:0] ENABLE_RESET  = 13'h0000;

  // acknowledge sequence
  localparam logic [14:0] SERVICE_ADDR  = 15'h00ff;
  localparam logic [2:0]  ACK_CYCLES    = 3'h7;
  localparam logic [2:0]  ACK_PUSH_STEP = 3'h2;
  localparam logic [2:0]  ACK_LOAD_STEP = 3'h6;

  // vector table offsets inside the block, high byte at the lower address
  localparam logic [7:0]  VEC_TRAP_OFS    = 8'hfe;
  localparam logic [7:0]  VEC_DEFAULT_OFS = 8'he0;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        instr_start;
    logic        skip_next;
    logic        trap;
    logic        return_from_interrupt;
    logic        boot_exec;
    logic        psw_gie_wr;
    logic        psw_gie_val;
    logic [14:0] next_pc;
  } mil_core_in_t;

  typedef struct packed {
    logic        push;
    logic [14:0] push_addr;
    logic        pc_load;
    logic [14:0] pc_value;
    logic        pop;
    logic        ack_busy;
  } mil_core_out_t;

endpackage

// ---- rtl/mil_maskable_interrupt_logic.sv ----
// mil_maskable_interrupt_logic: pending/enable flags, fixed-priority arbitration,
// seven-cycle acknowledge and return handling for the core.
// assumes source strobes and core signals are synchronous to i_clk.
//
// Function
// - fourteen vectored sources: software trap, thirteen maskable, default lowest entry
// - trap is highest, default entry lowest; maskable sources have fixed rank
// - every source but the trap has its own enable bit and pending flag
// - pending flag sets on each source event whether enabled or not
// - pending and enable bits are software readable and writable registers
// - maskable source fires only if enabled, global enable set, no trap service
// - evaluate at instruction start; highest qualifying wins, others stay pending
// - reset clears all pending flags, enables and global enable
// - already pending flag fires at once when enables become set
// - interrupt during an instruction waits until next normal instruction start
// - a pending skip completes before the interrupt is acknowledged
// - acknowledge start clears global enable automatically
// - acknowledge pushes address of the instruction about to execute
// - acknowledge loads program counter with service address 00ff
// - whole acknowledge sequence lasts seven clock cycles
// - return sets global enable, pops saved address into program counter
// - after return, still pending qualifying sources are serviced at once
// - boot memory execution blocks interrupts, global enable untouched
// - during boot execution repeat events of pending source are lost; logic sets pending on every event, boot or not
// - trap vector sits at top two bytes of table, high byte first
`timescale 1ns/100ps
`default_nettype none

module mil_maskable_interrupt_logic
  import mil_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_resetn,
  input  wire logic [12:0]          i_src_event,
  input  wire mil_pkg::mil_core_in_t  i_core,
  output var  mil_pkg::mil_core_out_t o_core,
  output logic                      o_global_interrupt_enable,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  import mil_pkg::*;

  typedef enum logic [1:0] {ST_RUN, ST_ACK} mil_state_t;

  // index 0 is highest maskable rank
  function automatic logic [3:0] mil_pick(input logic [12:0] req);
    logic [3:0] idx;
    idx = 4'hf;
    for (int i = NUM_MASKABLE - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // table offset of a rank; maskable rank i sits below trap and reserved slot
  function automatic logic [7:0] mil_vec_ofs(input logic [3:0] idx);
    logic [7:0] ofs;
    ofs = VEC_DEFAULT_OFS;
    if (idx != 4'hf) begin
      ofs = VEC_TRAP_OFS - 8'h04 - {3'h0, idx, 1'b0};
    end
    return ofs;
  endfunction

  logic [12:0]   pending_reg;
  logic [12:0]   enable_reg;
  logic          gie_reg;
  logic          nmi_active_reg;
  logic          trap_pend_reg;
  mil_state_t    state_reg;
  logic [2:0]    ack_cnt_reg;
  logic [14:0]   ret_addr_reg;
  logic [7:0]    vec_ofs_reg;
  mil_core_out_t core_reg;

  logic          aw_held_reg;
  logic [7:0]    aw_addr_reg;
  logic          w_held_reg;
  logic [31:0]   w_data_reg;
  logic [3:0]    w_strb_reg;

  logic [12:0]   active;
  logic          take_mask;
  logic          take_trap;
  logic          wr_fire;
  logic [12:0]   sw_wr_pend;
  logic [12:0]   sw_wr_en;
  logic [12:0]   pend_sets;
  logic [31:0]   rd_word;
  logic          rd_hit;
  logic          wr_hit;

  ////////////////////////////////////////////////////////////////////////////
  // qualification and arbitration

  always_comb begin
    active    = pending_reg & enable_reg;
    // boundary only when core starts a normal instruction, not a skip
    take_trap = i_core.instr_start && !i_core.skip_next
                && !i_core.boot_exec && state_reg == ST_RUN
                && (trap_pend_reg || i_core.trap);
    take_mask = i_core.instr_start && !i_core.skip_next
                && !i_core.boot_exec
                && state_reg == ST_RUN && gie_reg && !nmi_active_reg
                && (|active) && !take_trap;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bus

  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_comb begin
    wr_hit     = aw_addr_reg == ADDR_PENDING || aw_addr_reg == ADDR_ENABLE
                 || aw_addr_reg == ADDR_STATUS;
    sw_wr_pend = 13'h0000;
    sw_wr_en   = 13'h0000;
    if (wr_fire && aw_addr_reg == ADDR_PENDING) begin
      sw_wr_pend = {w_strb_reg[1] ? 5'h1f : 5'h00, w_strb_reg[0] ? 8'hff : 8'h00};
    end
    if (wr_fire && aw_addr_reg == ADDR_ENABLE) begin
      sw_wr_en = {w_strb_reg[1] ? 5'h1f : 5'h00, w_strb_reg[0] ? 8'hff : 8'h00};
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      aw_held_reg   <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_held_reg    <= 1'b0;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    unique case ({s_axi_araddr[7:2], 2'b00})
      ADDR_PENDING:  rd_word = {19'h00000, pending_reg};
      ADDR_ENABLE:   rd_word = {19'h00000, enable_reg};
      ADDR_STATUS: begin
        rd_word[STAT_GIE_BIT]  = gie_reg;
        rd_word[STAT_NMI_BIT]  = nmi_active_reg;
        rd_word[STAT_BOOT_BIT] = i_core.boot_exec;
        rd_word[STAT_ACK_BIT]  = state_reg == ST_ACK;
      end
      ADDR_VECTOR:   rd_word = {24'h000000, vec_ofs_reg};
      ADDR_RET_ADDR: rd_word = {17'h00000, ret_addr_reg};
      default:       rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending and enable flags

  always_comb begin
    // every source event sets its pending flag, during boot execution too
    pend_sets = i_src_event;
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pending_reg <= PENDING_RESET;
      enable_reg  <= ENABLE_RESET;
    end else begin
      // hardware set wins over a software clear in the same cycle
      pending_reg <= ((pending_reg & ~sw_wr_pend) | (w_data_reg[12:0] & sw_wr_pend))
                     | pend_sets;
      enable_reg  <= (enable_reg & ~sw_wr_en) | (w_data_reg[12:0] & sw_wr_en);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // global enable, trap service and acknowledge sequence

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      gie_reg <= 1'b0;
    end else if (take_mask || take_trap) begin
      gie_reg <= 1'b0;
    end else if (i_core.return_from_interrupt) begin
      gie_reg <= 1'b1;
    end else if (wr_fire && aw_addr_reg == ADDR_STATUS && w_strb_reg[0]) begin
      gie_reg <= w_data_reg[STAT_GIE_BIT];
    end else if (i_core.psw_gie_wr) begin
      gie_reg <= i_core.psw_gie_val;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      trap_pend_reg  <= 1'b0;
      nmi_active_reg <= 1'b0;
    end else begin
      if (take_trap) begin
        trap_pend_reg  <= 1'b0;
        nmi_active_reg <= 1'b1;
      end else begin
        if (i_core.trap) begin
          trap_pend_reg <= 1'b1;
        end
        if (i_core.return_from_interrupt) begin
          nmi_active_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg    <= ST_RUN;
      ack_cnt_reg  <= 3'h0;
      ret_addr_reg <= 15'h0000;
      vec_ofs_reg  <= VEC_DEFAULT_OFS;
    end else begin
      unique case (state_reg)
        ST_RUN: begin
          if (take_mask || take_trap) begin
            state_reg    <= ST_ACK;
            ack_cnt_reg  <= 3'h1;
            ret_addr_reg <= i_core.next_pc;
            vec_ofs_reg  <= take_trap ? VEC_TRAP_OFS
                            : mil_vec_ofs(mil_pick(active));
          end
        end
        ST_ACK: begin
          if (ack_cnt_reg == ACK_CYCLES) begin
            state_reg <= ST_RUN;
          end else begin
            ack_cnt_reg <= ack_cnt_reg + 3'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      core_reg <= '0;
    end else begin
      core_reg.push      <= state_reg == ST_ACK && ack_cnt_reg == ACK_PUSH_STEP;
      core_reg.push_addr <= ret_addr_reg;
      core_reg.pc_load   <= state_reg == ST_ACK && ack_cnt_reg == ACK_LOAD_STEP;
      core_reg.pc_value  <= SERVICE_ADDR;
      core_reg.pop       <= i_core.return_from_interrupt;
      core_reg.ack_busy  <= (take_mask || take_trap)
                            || (state_reg == ST_ACK && ack_cnt_reg != ACK_CYCLES);
    end
  end

  assign o_core                    = core_reg;
  assign o_global_interrupt_enable = gie_reg;

endmodule

`default_nettype wire

// ---- test/mil_assertions.sv ----
// mil_assertions: port checks of acknowledge, return and blocking
// assumes a bind to mil_maskable_interrupt_logic, one clock domain
`timescale 1ns/100ps
`default_nettype none
module mil_assertions
  import mil_pkg::*;
(
  input wire logic                   i_clk,
  input wire logic                   i_resetn,
  input wire mil_pkg::mil_core_in_t  i_core,
  input wire mil_pkg::mil_core_out_t o_core,
  input wire logic                   o_global_interrupt_enable
);
  import mil_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  //////////////////////////////
  sequence s_ack_start;
    $rose(o_core.ack_busy) && !o_global_interrupt_enable;
  endsequence
  sequence s_ack_steps;
    ##2 o_core.push ##4 o_core.pc_load ##1 !o_core.ack_busy;
  endsequence
  a_ack_clears_gie: assert property ($rose(o_core.ack_busy) |-> s_ack_start)
    else $error("global enable still set at acknowledge");
  a_ack_step_order: assert property (s_ack_start |-> s_ack_steps)
    else $error("push or load out of place");
  a_ack_seven_cycles: assert property ($rose(o_core.ack_busy) |-> o_core.ack_busy[*7])
    else $error("acknowledge shorter than seven cycles");
  a_push_ret_addr: assert property ($rose(o_core.ack_busy) |->
    ##2 o_core.push_addr == $past(i_core.next_pc, 3))
    else $error("wrong return address pushed");
  a_pc_service: assert property (o_core.pc_load |-> o_core.pc_value == SERVICE_ADDR)
    else $error("wrong service address");
  a_return_from_interrupt_pop_gie: assert property (i_core.return_from_interrupt |=> o_core.pop && o_global_interrupt_enable)
    else $error("return did not pop or set enable");
  a_boot_blocks: assert property (i_core.instr_start && i_core.boot_exec
    |=> !$rose(o_core.ack_busy))
    else $error("acknowledge during boot execution");
  a_skip_blocks: assert property (i_core.instr_start && i_core.skip_next
    |=> !$rose(o_core.ack_busy))
    else $error("acknowledge on a skipped instruction");
  a_boot_keeps_gie: assert property (i_core.boot_exec && !o_core.ack_busy && !i_core.psw_gie_wr
    |=> $stable(o_global_interrupt_enable))
    else $error("global enable changed in boot execution");
endmodule
`default_nettype wire

// ---- test/mil_core_model.sv ----
// mil_core_model: processor core stand-in making instruction boundaries
// assumes i_req comes from bench software and i_ack from the interrupt logic
`timescale 1ns/100ps
`default_nettype none
module mil_core_model
  import mil_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_resetn,
  input  wire mil_pkg::mil_core_in_t  i_req,
  input  wire mil_pkg::mil_core_out_t i_ack,
  output var  mil_pkg::mil_core_in_t  o_core
);
  import mil_pkg::*;
  logic [1:0] step_reg;
  //////////////////////////////
  // four-cycle instructions, stalled while the acknowledge runs
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      step_reg <= 2'h0;
    end else if (!i_ack.ack_busy) begin
      step_reg <= step_reg + 2'h1;
    end
  end
  always_comb begin
    o_core = i_req;
    o_core.instr_start = (step_reg == 2'h3) && !i_ack.ack_busy;
    o_core.trap = i_req.trap && o_core.instr_start;
    o_core.return_from_interrupt = i_req.return_from_interrupt && o_core.instr_start;
  end
endmodule
`default_nettype wire

// ---- test/test_maskable_interrupt_logic.sv ----
// test_maskable_interrupt_logic: self-checking bench for the interrupt logic
// assumes mil_core_model as the core and mil_assertions bound to the design
`timescale 1ns/100ps
`default_nettype none
module test_maskable_interrupt_logic;
  import mil_pkg::*;
  logic          i_clk = 1'b0;
  logic          i_resetn = 1'b0;
  logic [12:0]   i_src_event = '0;
  mil_core_in_t  req = '0;
  mil_core_in_t  i_core;
  mil_core_out_t o_core;
  logic          o_global_interrupt_enable;
  logic [7:0]    s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]   s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]    s_axi_wstrb = 4'hf;
  logic [1:0]    wr_q[$];
  logic          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic          s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]    s_axi_bresp, s_axi_rresp;
  logic [34:0]   rd_q[$];
  logic [14:0]   push_q[$];
  logic [34:0]   note;
  logic [14:0]   pc;
  logic [12:0]   ev;
  int            num_errors = 0, compares = 0;
  always #50 i_clk = ~i_clk;
  mil_maskable_interrupt_logic mil_maskable_interrupt_logic_i (.i_clk, .i_resetn, .i_src_event,
    .i_core, .o_core, .o_global_interrupt_enable, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  mil_core_model mil_core_model_i (.i_clk, .i_resetn, .i_req(req), .i_ack(o_core),
    .o_core(i_core));
  //////////////////////////////
  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r = RESP_OKAY, input logic [3:0] s = 4'hf);
    logic aw = 1'b0;
    logic w = 1'b0;
    wr_q.push_back(r);
    @(posedge i_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge i_clk);
      if (s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge i_clk);
    s_axi_bready <= 1'b0;
  endtask
  // note holds data-check flag, response and data
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
    rd_q.push_back({r == RESP_OKAY, r, d});
    @(posedge i_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge i_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge i_clk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic evt(input logic [12:0] e);
    @(posedge i_clk);
    i_src_event <= e;
    @(posedge i_clk);
    i_src_event <= '0;
  endtask
  task automatic core_op(input logic trap);
    @(posedge i_clk);
    if (trap) req.trap <= 1'b1;
    else req.return_from_interrupt <= 1'b1;
    @(posedge i_clk iff (i_core.trap || i_core.return_from_interrupt));
    req.trap <= 1'b0;
    req.return_from_interrupt <= 1'b0;
  endtask
  // every expected acknowledge must have happened by now
  task automatic settle();
    repeat (40) @(posedge i_clk);
    chk(35'(push_q.size()), 35'h0);
  endtask
  always @(posedge i_clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      note = rd_q.pop_front();
      chk({note[34], s_axi_rresp, note[34] ? s_axi_rdata : 32'h0}, note);
    end
    if (s_axi_bvalid && s_axi_bready) chk(35'(s_axi_bresp), 35'(wr_q.pop_front()));
    if (o_core.push && push_q.size() == 0) chk(35'h1, 35'h0);
    else if (o_core.push) chk(35'(o_core.push_addr), 35'(push_q.pop_front()));
  end
  initial begin
    #500000;
    num_errors++;
    stop_test();
  end
  initial begin
    ev = 13'($urandom(32'ha3a0b4e7));
    pc = 15'($urandom());
    req.next_pc <= pc;
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    axi_rd(ADDR_PENDING, RESP_OKAY, 32'h0);
    axi_rd(ADDR_ENABLE, RESP_OKAY, 32'h0);
    axi_rd(ADDR_STATUS, RESP_OKAY, 32'h0);
    axi_rd(8'h40, RESP_SLVERR, 32'h0);
    evt(ev);
    axi_rd(ADDR_PENDING, RESP_OKAY, 32'(ev));
    axi_wr(ADDR_PENDING, 32'h28);
    axi_wr(ADDR_ENABLE, 32'h28);
    axi_wr(ADDR_ENABLE, 32'h1f37, RESP_OKAY, 4'h2);
    axi_rd(ADDR_ENABLE, RESP_OKAY, 32'h1f28);
    axi_wr(8'h40, 32'h0, RESP_SLVERR);
    settle();
    push_q.push_back(pc);
    axi_wr(ADDR_STATUS, 32'h1);
    settle();
    axi_rd(ADDR_VECTOR, RESP_OKAY, 32'hf4);
    axi_rd(ADDR_RET_ADDR, RESP_OKAY, 32'(pc));
    axi_rd(ADDR_STATUS, RESP_OKAY, 32'h0);
    axi_rd(ADDR_PENDING, RESP_OKAY, 32'h28);
    axi_wr(ADDR_PENDING, 32'h20);
    push_q.push_back(pc);
    core_op(1'b0);
    settle();
    axi_wr(ADDR_PENDING, 32'h0);
    core_op(1'b0);
    req.skip_next <= 1'b1;
    evt(13'h8);
    settle();
    push_q.push_back(pc);
    req.skip_next <= 1'b0;
    settle();
    axi_wr(ADDR_PENDING, 32'h0);
    core_op(1'b0);
    req.boot_exec <= 1'b1;
    evt(13'h8);
    settle();
    evt(13'h8);
    axi_rd(ADDR_PENDING, RESP_OKAY, 32'h8);
    axi_rd(ADDR_STATUS, RESP_OKAY, 32'h5);
    push_q.push_back(pc);
    req.boot_exec <= 1'b0;
    settle();
    axi_wr(ADDR_PENDING, 32'h0);
    core_op(1'b0);
    axi_wr(ADDR_STATUS, 32'h0);
    push_q.push_back(pc);
    core_op(1'b1);
    settle();
    axi_rd(ADDR_VECTOR, RESP_OKAY, 32'hfe);
    req.psw_gie_val <= 1'b1;
    req.psw_gie_wr <= 1'b1;
    @(posedge i_clk);
    req.psw_gie_wr <= 1'b0;
    evt(13'h20);
    axi_rd(ADDR_STATUS, RESP_OKAY, 32'h3);
    settle();
    push_q.push_back(pc);
    core_op(1'b0);
    settle();
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    axi_rd(ADDR_PENDING, RESP_OKAY, 32'h0);
    axi_rd(ADDR_ENABLE, RESP_OKAY, 32'h0);
    axi_rd(ADDR_STATUS, RESP_OKAY, 32'h0);
    stop_test();
  end
endmodule
bind mil_maskable_interrupt_logic mil_assertions mil_assertions_i (.i_clk, .i_resetn, .i_core,
  .o_core, .o_global_interrupt_enable);
`default_nettype wire
